// [common/flow_setup_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite register word per offset
// Notes:   included by the setup block and its digit fields
`ifndef FLOW_SETUP_DEFS_SVH
`define FLOW_SETUP_DEFS_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_CMD       8'h04
`define OFS_READING   8'h08
`define OFS_LEVELS    8'h0c
`define OFS_TIMING    8'h10
`define OFS_STATUS    8'h14
`define OFS_TOTAL     8'h18
`define OFS_FSFLOW    8'h1c
`define OFS_STOPVOL   8'h20

// command word fields
`define CMD_KEY_LSB     0
`define CMD_SCREEN_LSB  4
`define CMD_TOT_CLEAR   8
`define CMD_VALVE_REQ   9
`define CMD_VALVE_LSB   10

// second field of paired registers
`define HI_FIELD_LSB    16

// reset values and level limit, levels in 0.1 % of full scale
`define RST_LEVEL       11'h014
`define RST_START       11'h014
`define RST_DELAY       16'h0000
`define LEVEL_MAX       11'h3e8

// digit entry: code of the decimal point symbol and the largest digit
`define POINT_CODE      4'ha
`define DIGIT_MAX       4'h9

// timing: one second of qualification and totalizing
`define SECOND_NS       1000000000
`define CLK_PERIOD_NS   100

// reading per mille times liters per minute over one second
`define VOL_DIVISOR     48'h00000000ea60

`endif

// [common/flow_setup_pkg.sv]
// Purpose: shared types of the flow alarm and totalizer setup block
// Assumes: nothing beyond the defines header
// Notes:   enum encodings count up from zero in declaration order
package flow_setup_pkg;

	typedef enum logic [2:0] {
		KEY_NONE, KEY_UP, step_down_key, KEY_ENTER, KEY_ESC
	} key_t;

	typedef enum logic [3:0] {
		SCR_IDLE, SCR_FSFLOW, SCR_RELAY1, SCR_RELAY2, SCR_ALMODE,
		SCR_ALLOW, SCR_ALHIGH, SCR_ALDELAY, SCR_ALACTION,
		SCR_TOTMODE, SCR_TOTSTART, SCR_STOPVOL
	} screen_t;

	typedef enum logic [1:0] {
		shut_valve_state, purge_valve_state, regulate_valve_state
	} valve_t;

	typedef enum logic [1:0] {
		ACT_NONE, ACT_BUZZER, ACT_VALVE
	} action_t;

	typedef enum logic [1:0] {
		RLY_NONE, RLY_LOW, RLY_HIGH, RLY_TOTSTOP
	} relay_t;

	typedef enum logic [1:0] {
		ALM_DISABLED, ALM_NONE, ALM_LOW, ALM_HIGH
	} alarm_code_t;

endpackage : flow_setup_pkg

// [rtl/digit_field.sv]
// Purpose: one keypad numeric entry field, digit by digit
// Assumes: step and advance inputs are one-cycle key pulses
// Notes:   digit DIGITS-1 is the leftmost, the cursor starts there
`timescale 1ns/1ps
`default_nettype none
`include "flow_setup_defs.svh"

module digit_field #(
	parameter int DIGITS = 6
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  stepUp,
	input  wire logic                  stepDown,
	input  wire logic                  advance,
	output logic      [4*DIGITS-1:0]   digits,
	output logic      [31:0]           wholeValue
);
	localparam int CW = (DIGITS > 1) ? $clog2(DIGITS) : 1;

	logic [CW-1:0]     cursor;
	logic [DIGITS-1:0] pointAt;
	logic              pointElsewhere;
	logic [3:0]        cur;
	logic [3:0]        next_cur;

	// flag every position that holds the point
	genvar gi;
	generate
		for (gi = 0; gi < DIGITS; gi++)
		begin : g_point
			assign pointAt[gi] = (digits[4*gi +: 4] == `POINT_CODE);
		end
	endgenerate

	assign cur = digits[4*cursor +: 4];
	assign pointElsewhere = |(pointAt & ~(DIGITS'(1) << cursor));

	// step the selected position, skipping the point if one exists
	always_comb
	begin
		next_cur = cur;
		if (stepUp)
		begin
			if (cur == `DIGIT_MAX)
				next_cur = pointElsewhere ? 4'h0 : `POINT_CODE;
			else if (cur == `POINT_CODE)
				next_cur = 4'h0;
			else
				next_cur = cur + 4'h1;
		end
		else if (stepDown)
		begin
			if (cur == 4'h0)
				next_cur = pointElsewhere ? `DIGIT_MAX : `POINT_CODE;
			else if (cur == `POINT_CODE)
				next_cur = `DIGIT_MAX;
			else
				next_cur = cur - 4'h1;
		end
	end

	// digits store; a second point can never be formed
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			digits <= '0;
		else
			digits[4*cursor +: 4] <= next_cur;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cursor <= CW'(DIGITS - 1);
		else if (advance)
			cursor <= (cursor == '0) ? CW'(DIGITS - 1) : cursor - 1'b1;
	end

	// whole part left of the point; the fraction is dropped
	always_comb
	begin
		logic stop;
		stop = 1'b0;
		wholeValue = '0;
		for (int i = DIGITS - 1; i >= 0; i--)
		begin
			if (!stop)
			begin
				if (digits[4*i +: 4] == `POINT_CODE)
					stop = 1'b1;
				else
					wholeValue = 32'(wholeValue * 32'd10
						+ 32'(digits[4*i +: 4]));
			end
		end
	end

endmodule : digit_field
`default_nettype wire

// [rtl/flow_alarm_totalizer_setup.sv]
// Purpose: setup and supervision of one flow channel: keypad entry,
//          alarm qualification, totalizer, relays, buzzer, valve
// Assumes: readings arrive over the bus in 0.1 % of full scale
// Notes:   key presses are written to the command register
`timescale 1ns/1ps
`default_nettype none
`include "flow_setup_defs.svh"

module flow_alarm_totalizer_setup
	import flow_setup_pkg::*;
#(
	parameter int SEC_CYCLES = `SECOND_NS / `CLK_PERIOD_NS,
	parameter int FS_DIGITS  = 6,
	parameter int SV_DIGITS  = 8
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             valvePowerOn,
	output logic             valveFullOpen,
	output logic             valveRegulate,
	output logic             buzzerOn,
	output logic [1:0]       relayClosed
);
	import flow_setup_pkg::*;

	logic [7:0]   awAddr;
	logic         awHeld;
	logic [31:0]  wData;
	logic [3:0]   wStrb;
	logic         wHeld;
	logic         doWrite;
	logic [31:0]  readWord;
	logic         readHit;
	logic         keyEv;
	key_t         key;
	screen_t      screen;
	logic         totClear;
	logic         valveReq;
	valve_t       valveAsk;
	logic         alarmEn;
	logic         totEn;
	action_t      alarmAction;
	relay_t       relayAsg [2];
	logic [10:0]  reading;
	logic [10:0]  setpoint;
	logic [10:0]  lowLevel;
	logic [10:0]  highLevel;
	logic [10:0]  totStart;
	logic [15:0]  alarmDelay;
	logic [31:0]  secCnt;
	logic         tick;
	logic [15:0]  qualSec;
	logic         lowCond;
	logic         highCond;
	logic         anyCond;
	logic         alarmLive;
	logic         lowActive;
	logic         highActive;
	alarm_code_t  alarmCode;
	logic [47:0]  total;
	logic         totStop;
	valve_t       valveMode;
	logic         shutLatch;
	logic [4*FS_DIGITS-1:0] fsDigits;
	logic [4*SV_DIGITS-1:0] svDigits;
	logic [31:0]  fsWhole;
	logic [31:0]  svWhole;

	// write address channel, taken independently of the data
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awready <= 1'b0;
			awHeld  <= 1'b0;
			awAddr  <= 8'h00;
		end
		else if (awready && awvalid)
		begin
			awAddr  <= awaddr;
			awHeld  <= 1'b1;
			awready <= 1'b0;
		end
		else if (doWrite)
			awHeld <= 1'b0;
		else if (!awHeld && !bvalid)
			awready <= 1'b1;
	end

	// write data channel
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wready <= 1'b0;
			wHeld  <= 1'b0;
			wData  <= 32'h00000000;
			wStrb  <= 4'h0;
		end
		else if (wready && wvalid)
		begin
			wData  <= wdata;
			wStrb  <= wstrb;
			wHeld  <= 1'b1;
			wready <= 1'b0;
		end
		else if (doWrite)
			wHeld <= 1'b0;
		else if (!wHeld && !bvalid)
			wready <= 1'b1;
	end

	assign doWrite = awHeld && wHeld && !bvalid;

	// write response; unmapped offsets answer slave error
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bvalid <= 1'b0;
			bresp  <= 2'b00;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp  <= (awAddr > `OFS_STOPVOL || awAddr[1:0] != 2'b00)
				? 2'b10 : 2'b00;
		end
		else if (bvalid && bready)
			bvalid <= 1'b0;
	end

	// command word decode: keys need the low two byte lanes
	assign keyEv    = doWrite && awAddr == `OFS_CMD && (&wStrb[1:0])
		&& key != KEY_NONE;
	assign key      = key_t'(wData[`CMD_KEY_LSB +: 3]);
	assign screen   = screen_t'(wData[`CMD_SCREEN_LSB +: 4]);
	assign totClear = doWrite && awAddr == `OFS_CMD && wStrb[1]
		&& wData[`CMD_TOT_CLEAR];
	assign valveReq = doWrite && awAddr == `OFS_CMD && wStrb[1]
		&& wData[`CMD_VALVE_REQ];
	assign valveAsk = valve_t'(wData[`CMD_VALVE_LSB +: 2]);

	// mode and action settings, from keys or a direct write
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alarmEn     <= 1'b0;
			totEn       <= 1'b0;
			alarmAction <= ACT_NONE;
			relayAsg[0] <= RLY_NONE;
			relayAsg[1] <= RLY_NONE;
		end
		else if (doWrite && awAddr == `OFS_CTRL && wStrb[0])
		begin
			alarmEn     <= wData[0];
			totEn       <= wData[1];
			alarmAction <= action_t'(wData[3:2]);
			relayAsg[0] <= relay_t'(wData[5:4]);
			relayAsg[1] <= relay_t'(wData[7:6]);
		end
		else if (keyEv)
		begin
			case (screen)
				SCR_ALMODE:
					alarmEn <= (key == KEY_UP) ? 1'b1
						: (key == step_down_key) ? 1'b0 : alarmEn;
				SCR_TOTMODE:
					totEn <= (key == KEY_UP) ? 1'b1
						: (key == step_down_key) ? 1'b0 : totEn;
				SCR_ALACTION:
					alarmAction <= (key == KEY_ESC) ? ACT_NONE
						: (key == KEY_UP) ? ACT_BUZZER
						: (key == step_down_key) ? ACT_VALVE
						: alarmAction;
				SCR_RELAY1:
					relayAsg[0] <= (key == KEY_UP)
						? relay_t'(relayAsg[0] + 2'd1)
						: (key == step_down_key)
						? relay_t'(relayAsg[0] - 2'd1)
						: relayAsg[0];
				SCR_RELAY2:
					relayAsg[1] <= (key == KEY_UP)
						? relay_t'(relayAsg[1] + 2'd1)
						: (key == step_down_key)
						? relay_t'(relayAsg[1] - 2'd1)
						: relayAsg[1];
				default:
					alarmEn <= alarmEn;
			endcase
		end
	end

	// measured reading and setpoint written by the host side
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reading  <= 11'h000;
			setpoint <= 11'h000;
		end
		else if (doWrite && awAddr == `OFS_READING)
		begin
			if (&wStrb[1:0])
				reading <= wData[10:0];
			if (&wStrb[3:2])
				setpoint <= wData[`HI_FIELD_LSB +: 11];
		end
	end

	// level, start and delay steps; levels saturate at full scale
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lowLevel   <= `RST_LEVEL;
			highLevel  <= `RST_LEVEL;
			totStart   <= `RST_START;
			alarmDelay <= `RST_DELAY;
		end
		else if (keyEv)
		begin
			case (screen)
				SCR_ALLOW:
					if (key == KEY_UP && lowLevel < `LEVEL_MAX)
						lowLevel <= lowLevel + 11'd1;
					else if (key == step_down_key && lowLevel != '0)
						lowLevel <= lowLevel - 11'd1;
				SCR_ALHIGH:
					if (key == KEY_UP && highLevel < `LEVEL_MAX)
						highLevel <= highLevel + 11'd1;
					else if (key == step_down_key && highLevel != '0)
						highLevel <= highLevel - 11'd1;
				SCR_TOTSTART:
					if (key == KEY_UP && totStart < `LEVEL_MAX)
						totStart <= totStart + 11'd1;
					else if (key == step_down_key && totStart != '0)
						totStart <= totStart - 11'd1;
				SCR_ALDELAY:
					if (key == KEY_UP && alarmDelay != '1)
						alarmDelay <= alarmDelay + 16'd1;
					else if (key == step_down_key && alarmDelay != '0)
						alarmDelay <= alarmDelay - 16'd1;
				default:
					lowLevel <= lowLevel;
			endcase
		end
	end

	// full-scale flow and stop volume digit fields
	digit_field #(.DIGITS(FS_DIGITS)) u_fs_field (
		.clk        (clk),
		.arst_n     (arst_n),
		.stepUp     (keyEv && screen == SCR_FSFLOW && key == KEY_UP),
		.stepDown   (keyEv && screen == SCR_FSFLOW
			&& key == step_down_key),
		.advance    (keyEv && screen == SCR_FSFLOW && key == KEY_ENTER),
		.digits     (fsDigits),
		.wholeValue (fsWhole)
	);

	digit_field #(.DIGITS(SV_DIGITS)) u_sv_field (
		.clk        (clk),
		.arst_n     (arst_n),
		.stepUp     (keyEv && screen == SCR_STOPVOL && key == KEY_UP),
		.stepDown   (keyEv && screen == SCR_STOPVOL
			&& key == step_down_key),
		.advance    (keyEv && screen == SCR_STOPVOL && key == KEY_ENTER),
		.digits     (svDigits),
		.wholeValue (svWhole)
	);

	// one-second tick shared by qualification and totalizing
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			secCnt <= 32'h00000000;
		else if (secCnt == 32'(SEC_CYCLES - 1))
			secCnt <= 32'h00000000;
		else
			secCnt <= secCnt + 32'd1;
	end

	assign tick = (secCnt == 32'(SEC_CYCLES - 1));

	assign lowCond  = alarmEn && setpoint >= reading
		&& (setpoint - reading) >= lowLevel;
	assign highCond = alarmEn && reading >= setpoint
		&& (reading - setpoint) >= highLevel;
	assign anyCond  = lowCond || highCond;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			qualSec <= 16'h0000;
		else if (!anyCond)
			qualSec <= 16'h0000;
		else if (tick && qualSec != '1)
			qualSec <= qualSec + 16'd1;
	end

	assign alarmLive = anyCond && qualSec >= alarmDelay;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lowActive  <= 1'b0;
			highActive <= 1'b0;
			alarmCode  <= ALM_DISABLED;
		end
		else
		begin
			lowActive  <= alarmLive && lowCond;
			highActive <= alarmLive && highCond;
			alarmCode  <= !alarmEn ? ALM_DISABLED
				: (alarmLive && highCond) ? ALM_HIGH
				: (alarmLive && lowCond) ? ALM_LOW : ALM_NONE;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			total <= 48'h000000000000;
		else if (totClear)
			total <= 48'h000000000000;
		else if (totEn && tick && reading >= totStart)
			total <= total + 48'(reading) * 48'(fsWhole);
	end

	// stop volume reached; total is kept in 1/60000 liter
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			totStop <= 1'b0;
		else
			totStop <= totEn && total >= 48'(svWhole) * `VOL_DIVISOR;
	end

	// buzzer: a new alarm wins over a silencing key in one cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			buzzerOn <= 1'b0;
		else if (alarmLive && alarmAction == ACT_BUZZER)
			buzzerOn <= 1'b1;
		else if (keyEv && (!anyCond || !alarmEn))
			buzzerOn <= 1'b0;
	end

	// valve mode; the latch remembers an alarm shutoff
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valveMode <= shut_valve_state;
			shutLatch <= 1'b0;
		end
		else if (alarmLive && alarmAction == ACT_VALVE)
		begin
			valveMode <= shut_valve_state;
			shutLatch <= 1'b1;
		end
		else if (valveReq)
		begin
			if (valveAsk == regulate_valve_state)
			begin
				if (!shutLatch || !anyCond)
				begin
					valveMode <= regulate_valve_state;
					shutLatch <= 1'b0;
				end
			end
			else if (valveAsk == shut_valve_state)
				valveMode <= shut_valve_state;
			else if (valveAsk == purge_valve_state && !shutLatch)
				valveMode <= purge_valve_state;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valvePowerOn  <= 1'b0;
			valveFullOpen <= 1'b0;
			valveRegulate <= 1'b0;
		end
		else
		begin
			valvePowerOn  <= valveMode != shut_valve_state;
			valveFullOpen <= valveMode == purge_valve_state;
			valveRegulate <= valveMode == regulate_valve_state;
		end
	end

	genvar ri;
	generate
		for (ri = 0; ri < 2; ri++)
		begin : g_relay
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					relayClosed[ri] <= 1'b0;
				else
					case (relayAsg[ri])
						RLY_LOW:     relayClosed[ri] <= lowActive;
						RLY_HIGH:    relayClosed[ri] <= highActive;
						RLY_TOTSTOP: relayClosed[ri] <= totStop;
						default:     relayClosed[ri] <= 1'b0;
					endcase
			end
		end
	endgenerate

	// read mux; the command register reads as zero
	always_comb
	begin
		readWord = 32'h00000000;
		readHit  = 1'b1;
		case (araddr)
			`OFS_CTRL:    readWord = {24'h0, relayAsg[1], relayAsg[0],
				alarmAction, totEn, alarmEn};
			`OFS_CMD:     readWord = 32'h00000000;
			`OFS_READING: readWord = {5'h0, setpoint, 5'h0, reading};
			`OFS_LEVELS:  readWord = {5'h0, highLevel, 5'h0, lowLevel};
			`OFS_TIMING:  readWord = {5'h0, totStart, alarmDelay};
			`OFS_STATUS:  readWord = {23'h0, shutLatch, relayClosed,
				valveMode, buzzerOn, totStop, alarmCode};
			`OFS_TOTAL:   readWord = total[31:0];
			`OFS_FSFLOW:  readWord = 32'(fsDigits);
			`OFS_STOPVOL: readWord = 32'(svDigits);
			default:      readHit  = 1'b0;
		endcase
	end

	// read channel: one cycle from address to data
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= 2'b00;
		end
		else if (arready && arvalid)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= readWord;
			rresp   <= readHit ? 2'b00 : 2'b10;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
		else if (!rvalid)
			arready <= 1'b1;
	end

endmodule : flow_alarm_totalizer_setup
`default_nettype wire

// [testbench/flow_plant_model.sv]
// Purpose: far side of the channel: valve drive seen by the plant
// Assumes: valve drive lines are levels
// Notes:   reports 0 shut, 1 purge, 2 regulating, 3 powered idle
`timescale 1ns/1ps
`default_nettype none
module flow_plant_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       valvePowerOn,
	input  wire logic       valveFullOpen,
	input  wire logic       valveRegulate,
	output logic      [1:0] plantState
);
	// unpowered valve closes by spring, else follows the mode
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			plantState <= 2'h0;
		else if (!valvePowerOn)
			plantState <= 2'h0;
		else if (valveFullOpen)
			plantState <= 2'h1;
		else
			plantState <= valveRegulate ? 2'h2 : 2'h3;
endmodule : flow_plant_model
`default_nettype wire

// [testbench/flow_setup_checker.sv]
// Purpose: port checker of the flow alarm and totalizer setup block
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module flow_setup_checker (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        rready,
	input  wire logic        valvePowerOn,
	input  wire logic        valveFullOpen,
	input  wire logic        valveRegulate
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// a taken response must reopen both write channels soon after
	sequence s_wr_taken;
		bvalid && bready;
	endsequence
	sequence s_wr_reopen;
		!bvalid ##[1:2] (awready && wready);
	endsequence

	a_wr_reopens: assert property (s_wr_taken |=> s_wr_reopen)
		else $error("write channels did not reopen");
	a_bresp_holds: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_wr_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	a_rd_blocked: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_resp_legal: assert property (bvalid |-> bresp inside {2'h0, 2'h2})
		else $error("write response code out of set");
	a_purge_power: assert property (valveFullOpen |->
		valvePowerOn && !valveRegulate)
		else $error("purge without full power");
	a_auto_power: assert property (valveRegulate |-> valvePowerOn)
		else $error("regulation without valve power");
endmodule : flow_setup_checker
`default_nettype wire

// [testbench/test_flow_alarm_totalizer_setup.sv]
// Purpose: self-checking bench of the flow alarm and totalizer setup
// Assumes: keys and settings reach the block over AXI4-Lite
// Notes:   one second is shortened to 20 clocks
`timescale 1ns/1ps
`default_nettype none
`include "flow_setup_defs.svh"
module test_flow_alarm_totalizer_setup;
	import flow_setup_pkg::*;
	logic        clk = '0, arst_n = '0, awvalid = '0, wvalid = '0;
	logic        bready = '0, arvalid = '0, rready = '0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rv;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  bresp, rresp, rr, rb, relayClosed, plantState;
	logic        awready, wready, bvalid, arready, rvalid, buzzerOn;
	logic        valvePowerOn, valveFullOpen, valveRegulate;
	int          numErrors = 0, cmpCount = 0;

	always #50 clk = ~clk;

	flow_alarm_totalizer_setup #(.SEC_CYCLES(20)) dut (
		.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .valvePowerOn,
		.valveFullOpen, .valveRegulate, .buzzerOn, .relayClosed);
	flow_plant_model plant (.clk, .arst_n, .valvePowerOn,
		.valveFullOpen, .valveRegulate, .plantState);

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			numErrors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// write cycle: each channel held until its own ready; bready comes
	// one edge late so that the response has to stand while it waits
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			numErrors++;
			report_and_stop();
		end
		bready <= 1'b1;
		@(posedge clk);
		rb = bresp;
		bready <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			numErrors++;
			report_and_stop();
		end
		// rready one edge late: read data must stand meanwhile
		rready <= 1'b1;
		@(posedge clk);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rchk

	task automatic press(input screen_t s, input key_t k, input int n);
		repeat (n) wr(`OFS_CMD, {24'h0, s, 1'b0, k});
	endtask : press

	task automatic valve(input valve_t m);
		wr(`OFS_CMD, {20'h0, m, 2'h2, 8'h0});
		repeat (3) @(posedge clk);
	endtask : valve

	task automatic rdg(input logic [10:0] r, input logic [10:0] sp);
		wr(`OFS_READING, {5'h0, sp, 5'h0, r});
		repeat (3) @(posedge clk);
	endtask : rdg

	task automatic t_regs;
		rchk(`OFS_LEVELS, 32'h00140014);
		rchk(`OFS_TIMING, 32'h00140000);
		rchk(`OFS_STATUS, 32'h0);
		rd(8'h24);
		chk(32'(rr), 32'h2);
		wr(8'h24, 32'h1);
		chk(32'(rb), 32'h2);
	endtask : t_regs

	task automatic t_digits;
		press(SCR_FSFLOW, KEY_UP, 10);
		rchk(`OFS_FSFLOW, 32'h00a00000);
		press(SCR_FSFLOW, KEY_UP, 1);
		rchk(`OFS_FSFLOW, 32'h0);
		press(SCR_FSFLOW, step_down_key, 1);
		rchk(`OFS_FSFLOW, 32'h00a00000);
		press(SCR_FSFLOW, KEY_ENTER, 1);
		press(SCR_FSFLOW, KEY_UP, 10);
		rchk(`OFS_FSFLOW, 32'h00a00000);
		press(SCR_FSFLOW, KEY_ENTER, 1);
		press(SCR_FSFLOW, KEY_UP, 1);
		rchk(`OFS_FSFLOW, 32'h00a01000);
		// cursor wraps to the leftmost place, point there becomes a 9
		press(SCR_FSFLOW, KEY_ENTER, 4);
		press(SCR_FSFLOW, step_down_key, 1);
		rchk(`OFS_FSFLOW, 32'h00901000);
	endtask : t_digits

	task automatic t_alarm;
		wr(`OFS_CTRL, 32'h95);
		rdg(11'd100, 11'd130);
		chk(32'(relayClosed), 32'h1);
		chk(32'(buzzerOn), 32'h1);
		press(SCR_IDLE, KEY_ESC, 1);
		chk(32'(buzzerOn), 32'h1);
		rdg(11'd150, 11'd130);
		chk(32'(relayClosed), 32'h2);
		rd(`OFS_STATUS);
		chk(rv & 32'h3, 32'(ALM_HIGH));
		rdg(11'd111, 11'd130);
		rd(`OFS_STATUS);
		chk(rv & 32'h3, 32'(ALM_NONE));
		press(SCR_IDLE, KEY_ESC, 1);
		chk(32'(buzzerOn), 32'h0);
	endtask : t_alarm

	task automatic t_delay;
		press(SCR_ALDELAY, KEY_UP, 2);
		press(SCR_ALLOW, KEY_UP, 1);
		press(SCR_ALHIGH, step_down_key, 1);
		rchk(`OFS_TIMING, 32'h00140002);
		rchk(`OFS_LEVELS, 32'h00130015);
		rdg(11'd100, 11'd130);
		repeat (8) @(posedge clk);
		rdg(11'd130, 11'd130);
		rdg(11'd100, 11'd130);
		repeat (8) @(posedge clk);
		chk(32'(relayClosed), 32'h0);
		repeat (60) @(posedge clk);
		chk(32'(relayClosed), 32'h1);
		rdg(11'd130, 11'd130);
		press(SCR_ALDELAY, step_down_key, 2);
		press(SCR_IDLE, KEY_ESC, 1);
	endtask : t_delay

	task automatic t_valve;
		valve(regulate_valve_state);
		chk(32'({valvePowerOn, valveRegulate}), 32'h3);
		valve(purge_valve_state);
		chk(32'(plantState), 32'h1);
		valve(regulate_valve_state);
		wr(`OFS_CTRL, 32'h89);
		rdg(11'd100, 11'd130);
		chk(32'(valvePowerOn), 32'h0);
		// operator asks for auto too early, then after clearing
		valve(regulate_valve_state);
		valve(purge_valve_state);
		chk(32'(plantState), 32'h0);
		rdg(11'd130, 11'd130);
		valve(regulate_valve_state);
		chk(32'(plantState), 32'h2);
	endtask : t_valve

	task automatic t_total;
		wr(`OFS_CTRL, 32'h0);
		// flow below the start value before totalizing is enabled
		rdg(11'd20, 11'd20);
		press(SCR_RELAY1, KEY_UP, 1);
		press(SCR_RELAY2, step_down_key, 1);
		press(SCR_ALMODE, KEY_UP, 1);
		press(SCR_ALACTION, step_down_key, 1);
		rchk(`OFS_CTRL, 32'hd9);
		press(SCR_ALACTION, KEY_ESC, 1);
		press(SCR_ALMODE, step_down_key, 1);
		press(SCR_TOTSTART, KEY_UP, 1);
		rchk(`OFS_TIMING, 32'h00150000);
		// stop volume 500 liters: more than one second of flow
		press(SCR_STOPVOL, KEY_ENTER, 5);
		press(SCR_STOPVOL, KEY_UP, 5);
		rchk(`OFS_STOPVOL, 32'h00000500);
		press(SCR_TOTMODE, KEY_UP, 1);
		rchk(`OFS_CTRL, 32'hd2);
		repeat (50) @(posedge clk);
		rchk(`OFS_TOTAL, 32'h0);
		rdg(11'd21, 11'd21);
		rd(`OFS_STATUS);
		chk(rv & 32'h4, 32'h0);
		repeat (50) @(posedge clk);
		rd(`OFS_TOTAL);
		chk(32'(rv !== 32'h0), 32'h1);
		rd(`OFS_STATUS);
		chk(rv & 32'h4, 32'h4);
		chk(32'(relayClosed), 32'h2);
		rdg(11'd0, 11'd0);
		wr(`OFS_CMD, 32'h100);
		rchk(`OFS_TOTAL, 32'h0);
	endtask : t_total

	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_digits();
		t_alarm();
		t_delay();
		t_valve();
		t_total();
		report_and_stop();
	end
endmodule : test_flow_alarm_totalizer_setup

bind flow_alarm_totalizer_setup flow_setup_checker portChecker (
	.clk, .arst_n, .awready, .wready, .bresp, .bvalid, .bready,
	.arready, .rdata, .rvalid, .rready, .valvePowerOn,
	.valveFullOpen, .valveRegulate);
`default_nettype wire
